// ==== src/aadc_ctrl.sv ====
// Control of the temperature, battery and external voltage converters.
`timescale 1ns/1ps
`default_nettype none
`include "aadc_cfg.svh"
module aadc_ctrl #(
    parameter int SEC_CYCLES = `AADC_SEC_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       full_power_mode,
    input  wire logic       battery_run_mode,
    input  wire logic       core_sleep_mode,
    output logic            bat_conv_req,
    output logic            tmp_conv_req,
    output logic            ext_conv_req,
    input  wire logic       bat_conv_ack,
    input  wire logic       tmp_conv_ack,
    input  wire logic       ext_conv_ack,
    input  wire logic       bat_conv_done,
    input  wire logic       tmp_conv_done,
    input  wire logic       ext_conv_done,
    input  wire logic [7:0] bat_code,
    input  wire logic [7:0] tmp_code,
    input  wire logic [7:0] ext_code,
    output logic            tmp_irq,
    output logic            bat_irq,
    output logic            ext_irq,
    output logic            low_battery_flag,
    output logic            pll_fault_clear
);

    // ****************************************************************
    // State and local signals
    // ****************************************************************
    aadc_pkg::aadc_state_s_t s;
    aadc_pkg::aadc_state_s_t next_s;

    logic       tmp_fire;
    logic       bat_fire;
    logic       core_run;
    logic       tmp_bg_ok;
    logic       bat_bg_ok;
    logic       want_bat;
    logic       want_tmp;
    logic       want_ext;
    logic       ack;
    logic       done;
    logic [7:0] tmp_diff;
    logic       tmp_hit;
    logic       bat_low;
    logic       wr_start;
    logic       wr_thr;
    logic       wr_delta;
    logic       wr_ivl;
    logic       wr_tmp;
    logic       wr_bat;
    logic       wr_ext;

    // ****************************************************************
    // Background interval timers
    // ****************************************************************
    aadc_interval #(
        .MIN_1 (`AADC_TMP_MIN_1),
        .MIN_2 (`AADC_TMP_MIN_2),
        .MIN_3 (`AADC_TMP_MIN_3)
    ) u_tmp_ivl (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .sec_tick (s.sec_tick),
        .interval (s.tper),
        .fire     (tmp_fire)
    );

    aadc_interval #(
        .MIN_1 (`AADC_BAT_MIN_1),
        .MIN_2 (`AADC_BAT_MIN_2),
        .MIN_3 (`AADC_BAT_MIN_3)
    ) u_bat_ivl (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .sec_tick (s.sec_tick),
        .interval (s.bper),
        .fire     (bat_fire)
    );

    // ****************************************************************
    // Mode gating
    // ****************************************************************
    assign core_run  = full_power_mode | battery_run_mode;
    assign tmp_bg_ok = full_power_mode | core_sleep_mode;
    assign bat_bg_ok = full_power_mode;

    // Single requests wait while the core sleeps; they are kept, not dropped.
    // A background request left pending across a mode change waits for a mode that allows it.
    assign want_bat = (s.start[`AADC_BIT_BAT_START] & core_run) | (s.bg_bat & bat_bg_ok);
    assign want_tmp = (s.start[`AADC_BIT_TMP_START] & core_run) | (s.bg_tmp & tmp_bg_ok);
    assign want_ext = s.start[`AADC_BIT_EXT_START] & core_run;

    // ****************************************************************
    // Converter handshake
    // ****************************************************************
    always_comb begin
        bat_conv_req = 1'b0;
        tmp_conv_req = 1'b0;
        ext_conv_req = 1'b0;
        if (s.st == aadc_pkg::AADC_ST_REQ) begin
            bat_conv_req = (s.ch == aadc_pkg::AADC_CH_BAT);
            tmp_conv_req = (s.ch == aadc_pkg::AADC_CH_TMP);
            ext_conv_req = (s.ch == aadc_pkg::AADC_CH_EXT);
        end
    end

    always_comb begin
        unique case (s.ch)
            aadc_pkg::AADC_CH_BAT: begin
                ack  = bat_conv_ack;
                done = bat_conv_done;
            end
            aadc_pkg::AADC_CH_TMP: begin
                ack  = tmp_conv_ack;
                done = tmp_conv_done;
            end
            aadc_pkg::AADC_CH_EXT: begin
                ack  = ext_conv_ack;
                done = ext_conv_done;
            end
            default: begin
                ack  = 1'b0;
                done = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Result comparisons
    // ****************************************************************
    assign tmp_diff = (tmp_code > s.ref_code) ? (tmp_code - s.ref_code)
                                              : (s.ref_code - tmp_code);

    always_comb begin
        if (s.single) begin
            tmp_hit = 1'b1;
        end else if (s.delta == `AADC_DELTA_OFF) begin
            tmp_hit = 1'b0;
        end else if (s.delta == `AADC_DELTA_ALWAYS) begin
            tmp_hit = 1'b1;
        end else begin
            tmp_hit = (tmp_diff > {5'h00, s.delta});
        end
    end

    assign bat_low = (bat_code < s.thr);

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    assign wr_start = sfr_wr & (sfr_addr == `AADC_ADDR_START);
    assign wr_thr   = sfr_wr & (sfr_addr == `AADC_ADDR_THRESHOLD);
    assign wr_delta = sfr_wr & (sfr_addr == `AADC_ADDR_DELTA_CFG);
    assign wr_ivl   = sfr_wr & (sfr_addr == `AADC_ADDR_INTERVAL_CFG);
    assign wr_tmp   = sfr_wr & (sfr_addr == `AADC_ADDR_TEMP_RESULT);
    assign wr_bat   = sfr_wr & (sfr_addr == `AADC_ADDR_BAT_RESULT);
    assign wr_ext   = sfr_wr & (sfr_addr == `AADC_ADDR_EXT_RESULT);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s          = s;
        next_s.tmp_irq  = 1'b0;
        next_s.bat_irq  = 1'b0;
        next_s.ext_irq  = 1'b0;
        next_s.low_set  = 1'b0;
        next_s.pll_clr  = 1'b0;
        next_s.sec_tick = 1'b0;

        // Second prescaler shared by both interval timers.
        if (s.sec_cnt >= 32'(SEC_CYCLES - 1)) begin
            next_s.sec_cnt  = 32'h00000000;
            next_s.sec_tick = 1'b1;
        end else begin
            next_s.sec_cnt = s.sec_cnt + 32'h00000001;
        end

        // Configuration registers.
        if (wr_thr) begin
            next_s.thr = sfr_wdata;
        end
        if (wr_delta) begin
            next_s.delta = sfr_wdata[`AADC_TDELTA_MSB:`AADC_TDELTA_LSB];
        end
        if (wr_ivl) begin
            next_s.tper = sfr_wdata[`AADC_TPER_MSB:`AADC_TPER_LSB];
            next_s.bper = sfr_wdata[`AADC_BPER_MSB:`AADC_BPER_LSB];
        end
        if (wr_tmp) begin
            next_s.tmp_res = sfr_wdata;
        end
        if (wr_bat) begin
            next_s.bat_res = sfr_wdata;
        end
        if (wr_ext) begin
            next_s.ext_res = sfr_wdata;
        end

        // Sequencer: one conversion at a time, battery before temperature before external.
        unique case (s.st)
            aadc_pkg::AADC_ST_IDLE: begin
                if (want_bat) begin
                    next_s.st     = aadc_pkg::AADC_ST_REQ;
                    next_s.ch     = aadc_pkg::AADC_CH_BAT;
                    next_s.single = s.start[`AADC_BIT_BAT_START] & core_run;
                end else if (want_tmp) begin
                    next_s.st     = aadc_pkg::AADC_ST_REQ;
                    next_s.ch     = aadc_pkg::AADC_CH_TMP;
                    next_s.single = s.start[`AADC_BIT_TMP_START] & core_run;
                end else if (want_ext) begin
                    next_s.st     = aadc_pkg::AADC_ST_REQ;
                    next_s.ch     = aadc_pkg::AADC_CH_EXT;
                    next_s.single = 1'b1;
                end
            end
            aadc_pkg::AADC_ST_REQ: begin
                if (ack) begin
                    next_s.st = aadc_pkg::AADC_ST_WAIT;
                    // A pending background request merges into this conversion.
                    unique case (s.ch)
                        aadc_pkg::AADC_CH_BAT: begin
                            next_s.bg_bat = 1'b0;
                            if (s.single) begin
                                next_s.start[`AADC_BIT_BAT_START] = 1'b0;
                            end
                        end
                        aadc_pkg::AADC_CH_TMP: begin
                            next_s.bg_tmp = 1'b0;
                            if (s.single) begin
                                next_s.start[`AADC_BIT_TMP_START] = 1'b0;
                            end
                        end
                        default: begin
                            next_s.start[`AADC_BIT_EXT_START] = 1'b0;
                        end
                    endcase
                end
            end
            aadc_pkg::AADC_ST_WAIT: begin
                if (done) begin
                    next_s.st = aadc_pkg::AADC_ST_IDLE;
                    unique case (s.ch)
                        aadc_pkg::AADC_CH_BAT: begin
                            if (s.single || bat_low) begin
                                next_s.bat_res = bat_code;
                                next_s.bat_irq = 1'b1;
                            end
                            next_s.low_set = bat_low;
                        end
                        aadc_pkg::AADC_CH_TMP: begin
                            if (tmp_hit) begin
                                next_s.tmp_res  = tmp_code;
                                next_s.ref_code = tmp_code;
                                next_s.tmp_irq  = 1'b1;
                            end
                        end
                        default: begin
                            next_s.ext_res = ext_code;
                            next_s.ext_irq = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                next_s.st = aadc_pkg::AADC_ST_IDLE;
            end
        endcase

        // Background requests; a firing timer sets after the acceptance cleared.
        if (tmp_fire && tmp_bg_ok) begin
            next_s.bg_tmp = 1'b1;
        end
        if (bat_fire && bat_bg_ok) begin
            next_s.bg_bat = 1'b1;
        end

        // Start bits: writing one sets, writing zero leaves; the set wins over acceptance.
        if (wr_start) begin
            if (sfr_wdata[`AADC_BIT_BAT_START]) begin
                next_s.start[`AADC_BIT_BAT_START] = 1'b1;
            end
            if (sfr_wdata[`AADC_BIT_TMP_START]) begin
                next_s.start[`AADC_BIT_TMP_START] = 1'b1;
            end
            if (sfr_wdata[`AADC_BIT_EXT_START]) begin
                next_s.start[`AADC_BIT_EXT_START] = 1'b1;
            end
            next_s.pll_clr = sfr_wdata[`AADC_BIT_PLL_CLEAR];
        end

        // Read data, registered one cycle after the address.
        unique case (sfr_addr)
            `AADC_ADDR_TEMP_RESULT:  next_s.rdata = s.tmp_res;
            `AADC_ADDR_START:        next_s.rdata = {5'h00, s.start};
            `AADC_ADDR_BAT_RESULT:   next_s.rdata = s.bat_res;
            `AADC_ADDR_EXT_RESULT:   next_s.rdata = s.ext_res;
            `AADC_ADDR_DELTA_CFG:    next_s.rdata = {2'h0, s.delta, 3'h0};
            `AADC_ADDR_INTERVAL_CFG: next_s.rdata = {4'h0, s.bper, s.tper};
            `AADC_ADDR_THRESHOLD:    next_s.rdata = s.thr;
            default:                 next_s.rdata = `AADC_RESET_BYTE;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sfr_rdata        = s.rdata;
    assign tmp_irq          = s.tmp_irq;
    assign bat_irq          = s.bat_irq;
    assign ext_irq          = s.ext_irq;
    assign low_battery_flag = s.low_set;
    assign pll_fault_clear  = s.pll_clr;

endmodule
`default_nettype wire

// ==== src/aadc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the auxiliary converter control.
`ifndef AADC_CFG_SVH
`define AADC_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define AADC_ADDR_TEMP_RESULT  8'hD7
`define AADC_ADDR_START        8'hD8
`define AADC_ADDR_BAT_RESULT   8'hDF
`define AADC_ADDR_EXT_RESULT   8'hEF
`define AADC_ADDR_DELTA_CFG    8'hF3
`define AADC_ADDR_INTERVAL_CFG 8'hF9
`define AADC_ADDR_THRESHOLD    8'hFA

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define AADC_BIT_BAT_START     0
`define AADC_BIT_TMP_START     1
`define AADC_BIT_EXT_START     2
`define AADC_BIT_PLL_CLEAR     7
`define AADC_TDELTA_LSB        3
`define AADC_TDELTA_MSB        5
`define AADC_TPER_LSB          0
`define AADC_TPER_MSB          1
`define AADC_BPER_LSB          2
`define AADC_BPER_MSB          3
`define AADC_DELTA_OFF         3'h0
`define AADC_DELTA_ALWAYS      3'h7
`define AADC_RESET_BYTE        8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define AADC_CLK_PERIOD_NS     10
`define AADC_SEC_NS            1000000000
`define AADC_SEC_CYCLES        (`AADC_SEC_NS / `AADC_CLK_PERIOD_NS)
`define AADC_SEC_PER_MIN       60
`define AADC_TMP_MIN_1         8
`define AADC_TMP_MIN_2         2
`define AADC_TMP_MIN_3         1
`define AADC_BAT_MIN_1         16
`define AADC_BAT_MIN_2         4
`define AADC_BAT_MIN_3         1

`endif

// ==== src/aadc_pkg.sv ====
// Types of the auxiliary converter control.
package aadc_pkg;

    typedef enum logic [1:0] {
        AADC_ST_IDLE,
        AADC_ST_REQ,
        AADC_ST_WAIT
    } aadc_state_t;

    // Lower code wins when several requests are pending.
    typedef enum logic [1:0] {
        AADC_CH_BAT,
        AADC_CH_TMP,
        AADC_CH_EXT
    } aadc_ch_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic       fire;
    } aadc_ivl_t;

    typedef struct packed {
        aadc_state_t st;
        aadc_ch_t    ch;
        logic        single;
        logic [2:0]  start;
        logic        bg_tmp;
        logic        bg_bat;
        logic [7:0]  tmp_res;
        logic [7:0]  bat_res;
        logic [7:0]  ext_res;
        logic [7:0]  thr;
        logic [2:0]  delta;
        logic [1:0]  tper;
        logic [1:0]  bper;
        logic [7:0]  ref_code;
        logic [31:0] sec_cnt;
        logic        sec_tick;
        logic [7:0]  rdata;
        logic        tmp_irq;
        logic        bat_irq;
        logic        ext_irq;
        logic        low_set;
        logic        pll_clr;
    } aadc_state_s_t;

endpackage

// ==== src/aadc_interval.sv ====
// Background interval timer counting seconds up to a selected number of minutes.
`timescale 1ns/1ps
`default_nettype none
`include "aadc_cfg.svh"
module aadc_interval #(
    parameter int MIN_1 = 8,
    parameter int MIN_2 = 2,
    parameter int MIN_3 = 1
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       sec_tick,
    input  wire logic [1:0] interval,
    output logic            fire
);

    aadc_pkg::aadc_ivl_t s;
    aadc_pkg::aadc_ivl_t next_s;
    logic [9:0]          last;

    always_comb begin
        unique case (interval)
            2'h1:    last = 10'(MIN_1 * `AADC_SEC_PER_MIN - 1);
            2'h2:    last = 10'(MIN_2 * `AADC_SEC_PER_MIN - 1);
            2'h3:    last = 10'(MIN_3 * `AADC_SEC_PER_MIN - 1);
            default: last = 10'h000;
        endcase
    end

    always_comb begin
        next_s      = s;
        next_s.fire = 1'b0;
        // Counting restarts whenever the interval is switched off.
        if (interval == 2'h0) begin
            next_s.cnt = 10'h000;
        end else if (sec_tick) begin
            // A shortened interval fires at once instead of wrapping.
            if (s.cnt >= last) begin
                next_s.cnt  = 10'h000;
                next_s.fire = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fire = s.fire;

endmodule
`default_nettype wire

// ==== bench/aadc_ctrl_properties.sv ====
// Concurrent checks on the ports of the converter control.
`timescale 1ns/1ps
`default_nettype none
`include "aadc_cfg.svh"
module aadc_ctrl_properties (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       core_sleep_mode,
    input wire logic       bat_conv_req,
    input wire logic       tmp_conv_req,
    input wire logic       ext_conv_req,
    input wire logic       bat_conv_ack,
    input wire logic       tmp_conv_ack,
    input wire logic       ext_conv_ack,
    input wire logic       bat_conv_done,
    input wire logic       tmp_conv_done,
    input wire logic       tmp_irq,
    input wire logic       bat_irq,
    input wire logic       low_battery_flag,
    input wire logic       pll_fault_clear
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence s_tmp_taken;
        tmp_conv_req && tmp_conv_ack;
    endsequence
    sequence s_thr_put;
        sfr_wr && sfr_addr == `AADC_ADDR_THRESHOLD
        ##1 !sfr_wr && sfr_addr == `AADC_ADDR_THRESHOLD;
    endsequence
    pll_clear_a: assert property (
        pll_fault_clear == $past(sfr_wr && sfr_addr == `AADC_ADDR_START && sfr_wdata[7]))
        else $error("pll clear pulse wrong");
    bat_req_hold_a: assert property (bat_conv_req && !bat_conv_ack |=> bat_conv_req)
        else $error("battery request dropped early");
    tmp_req_drop_a: assert property (s_tmp_taken |=> !tmp_conv_req)
        else $error("temperature request kept after accept");
    ext_req_drop_a: assert property (ext_conv_req && ext_conv_ack |=> !ext_conv_req)
        else $error("external request kept after accept");
    one_request_a: assert property ($onehot0({bat_conv_req, tmp_conv_req, ext_conv_req}))
        else $error("two requests at once");
    low_flag_irq_a: assert property (low_battery_flag |-> bat_irq)
        else $error("low flag without battery interrupt");
    tmp_irq_cause_a: assert property (tmp_irq |-> $past(tmp_conv_done))
        else $error("temperature interrupt without result");
    bat_irq_cause_a: assert property (bat_irq |-> $past(bat_conv_done))
        else $error("battery interrupt without result");
    sleep_no_ext_a: assert property (
        core_sleep_mode && $past(core_sleep_mode) |-> !$rose(ext_conv_req))
        else $error("single request served in sleep");
    thr_readback_a: assert property (s_thr_put |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("threshold readback wrong");
endmodule
bind aadc_ctrl aadc_ctrl_properties u_aadc_ctrl_properties (
    .mclk, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .core_sleep_mode,
    .bat_conv_req, .tmp_conv_req, .ext_conv_req, .bat_conv_ack, .tmp_conv_ack,
    .ext_conv_ack, .bat_conv_done, .tmp_conv_done, .tmp_irq, .bat_irq,
    .low_battery_flag, .pll_fault_clear
);
`default_nettype wire

// ==== bench/aadc_conv_model.sv ====
// Behavioural converter that accepts a request and later reports a code.
`timescale 1ns/1ps
`default_nettype none
module aadc_conv_model #(
    parameter int LAG = 0
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       req,
    input  wire logic [7:0] value,
    output logic            ack,
    output logic            done,
    output logic      [7:0] code
);
    // The code bus is inverted outside the done cycle, so a late sample cannot pass.
    int   cnt;
    logic busy;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            busy <= 1'b0;
            ack <= 1'b0;
            done <= 1'b0;
            code <= 8'hFF;
        end else begin
            ack <= 1'b0;
            done <= 1'b0;
            code <= ~value;
            if (busy || req) begin
                cnt <= cnt + 1;
            end
            if (cnt >= LAG && !busy && req) begin
                ack <= 1'b1;
                busy <= 1'b1;
                cnt <= 0;
            end
            if (cnt >= LAG && busy) begin
                done <= 1'b1;
                code <= value;
                busy <= 1'b0;
                cnt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/aadc_ctrl_tb.sv ====
// Self-checking bench of the auxiliary converter control.
`timescale 1ns/1ps
`default_nettype none
`include "aadc_cfg.svh"
module aadc_ctrl_tb;
    // A short second keeps the one-minute interval at 120 cycles and the longest, 16 minutes, at 1920.
    localparam int SEC = 2;
    localparam int GAP = 120 * SEC + 10;
    logic [23:0] rows [8] = '{24'hFAA5A5, 24'hF3FF38, 24'hF9F000, 24'hD87800,
                              24'h105500, 24'hD73C3C, 24'hDF5A5A, 24'hEF9999};
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  bval = 8'h00, tval = 8'h00, xval = 8'h00, ord = 8'h00;
    logic [7:0]  rdata, bcode, tcode, xcode;
    logic [2:0]  mode = 3'h1;
    logic [2:0]  req, ack, done, irq;
    logic        low, pclr;
    int          n_fail = 0, n_compared = 0, nb = 0, nt = 0, ne = 0, nl = 0, np = 0, t0;
    always #5 mclk = ~mclk;
    aadc_ctrl #(.SEC_CYCLES(SEC)) u_aadc_ctrl (
        .mclk, .arst_n, .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .full_power_mode(mode[0]), .battery_run_mode(mode[1]), .core_sleep_mode(mode[2]),
        .bat_conv_req(req[0]), .tmp_conv_req(req[1]), .ext_conv_req(req[2]),
        .bat_conv_ack(ack[0]), .tmp_conv_ack(ack[1]), .ext_conv_ack(ack[2]),
        .bat_conv_done(done[0]), .tmp_conv_done(done[1]), .ext_conv_done(done[2]),
        .bat_code(bcode), .tmp_code(tcode), .ext_code(xcode), .bat_irq(irq[0]),
        .tmp_irq(irq[1]), .ext_irq(irq[2]), .low_battery_flag(low), .pll_fault_clear(pclr));
    aadc_conv_model #(.LAG(2)) u_bat (.mclk, .arst_n, .req(req[0]), .value(bval),
        .ack(ack[0]), .done(done[0]), .code(bcode));
    aadc_conv_model #(.LAG(0)) u_tmp (.mclk, .arst_n, .req(req[1]), .value(tval),
        .ack(ack[1]), .done(done[1]), .code(tcode));
    aadc_conv_model #(.LAG(4)) u_ext (.mclk, .arst_n, .req(req[2]), .value(xval),
        .ack(ack[2]), .done(done[2]), .code(xcode));
    always @(posedge mclk) begin
        if (irq[0]) nb++;
        if (irq[1]) nt++;
        if (irq[2]) ne++;
        if (low) nl++;
        if (pclr) np++;
        if (|irq) ord = {ord[5:0], irq[2], irq[1]};
    end
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge mclk) #1 wr = 1'b0;
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) #1 addr = a;
        @(posedge mclk) #1 check(rdata, e);
    endtask
    task automatic wait_for(ref int c, input int target);
        int k = 0;
        while (c < target && k < 400) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (c < target) begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        #1 arst_n = 1'b1;
        foreach (rows[i]) get(rows[i][23:16], 8'h00);
        foreach (rows[i]) begin
            put(rows[i][23:16], rows[i][15:8]);
            get(rows[i][23:16], rows[i][7:0]);
        end
        idle(GAP);
        check(8'(nb + nt + ne), 8'h00);
        bval = 8'h80;
        tval = 8'h41;
        xval = 8'hC3;
        put(`AADC_ADDR_START, 8'h07);
        wait_for(ne, 1);
        check(ord, 8'h06);
        check(8'(nl), 8'h01);
        get(`AADC_ADDR_BAT_RESULT, 8'h80);
        get(`AADC_ADDR_TEMP_RESULT, 8'h41);
        get(`AADC_ADDR_EXT_RESULT, 8'hC3);
        get(`AADC_ADDR_START, 8'h00);
        put(`AADC_ADDR_START, 8'h80);
        idle(2);
        check(8'(np), 8'h01);
        bval = 8'hC0;
        put(`AADC_ADDR_START, 8'h01);
        wait_for(nb, 2);
        check(8'(nl), 8'h01);
        get(`AADC_ADDR_BAT_RESULT, 8'hC0);
        // Software order: single done, then delta, then interval.
        tval = 8'h43;
        put(`AADC_ADDR_DELTA_CFG, 8'h10);
        put(`AADC_ADDR_INTERVAL_CFG, 8'h0F);
        idle(GAP);
        check(8'(nt), 8'h01);
        check(8'(nl), 8'h01);
        get(`AADC_ADDR_TEMP_RESULT, 8'h41);
        tval = 8'h44;
        idle(GAP);
        check(8'(nt), 8'h02);
        get(`AADC_ADDR_TEMP_RESULT, 8'h44);
        bval = 8'h20;
        put(`AADC_ADDR_DELTA_CFG, 8'h38);
        idle(GAP);
        check(8'(nt > 2), 8'h01);
        check(8'(nl > 1), 8'h01);
        get(`AADC_ADDR_BAT_RESULT, 8'h20);
        mode = 3'h2;
        idle(10);
        t0 = nt;
        idle(GAP);
        check(8'(nt - t0), 8'h00);
        put(`AADC_ADDR_START, 8'h02);
        wait_for(nt, t0 + 1);
        check(8'(nt - t0), 8'h01);
        mode = 3'h4;
        t0 = nt;
        put(`AADC_ADDR_START, 8'h04);
        idle(GAP);
        check(8'(ne), 8'h01);
        check(8'(nt > t0), 8'h01);
        mode = 3'h1;
        wait_for(ne, 2);
        // Reset in mid-run: configuration returns to zero and background work stops.
        arst_n = 1'b0;
        idle(2);
        arst_n = 1'b1;
        t0 = nb + nt + ne;
        get(`AADC_ADDR_INTERVAL_CFG, 8'h00);
        get(`AADC_ADDR_THRESHOLD, 8'h00);
        get(`AADC_ADDR_TEMP_RESULT, 8'h00);
        idle(GAP);
        check(8'(nb + nt + ne - t0), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
